// ==== ssrb_pkg.sv ====
// Shared constants for the synthesizer serial register bank.
// Assumes a single clock domain on mclk; serial pins are asynchronous.
package ssrb_pkg;
   localparam int WORD_W = 24;
   // Control codes in the three low bits
   localparam logic [2:0] SEL_FREQ = 3'h0;
   localparam logic [2:0] SEL_MODREF = 3'h1;
   localparam logic [2:0] SEL_PHASE = 3'h2;
   localparam logic [2:0] SEL_FUNC = 3'h3;
   localparam logic [2:0] SEL_TIMER = 3'h4;
   localparam logic [2:0] SEL_PDOWN = 3'h5;
   localparam logic [2:0] SEL_OUTSEL = 3'h6;
   localparam logic [2:0] SEL_TEST = 3'h7;
   // Frequency word fields
   localparam int INT_LSB = 15;
   localparam int FRACTION_NUMERATOR_LSB = 3;
   // Modulus/reference fields
   localparam int BOOST_BIT = 23;
   localparam int HALVE_BIT = 22;
   localparam int PRESC_BIT = 20;
   localparam int DOUBLER_BIT = 19;
   localparam int RDIV_LSB = 15;
   localparam int MOD_LSB = 3;
   // Phase, function, timer, output select, power-down fields
   localparam int PHASE_LSB = 3;
   localparam int GND_BIT = 5;
   localparam int POL_BIT = 3;
   localparam int TOUT_LSB = 5;
   localparam int TSEL_LSB = 3;
   localparam int MUX_LSB = 3;
   localparam int LDSET_LSB = 12;
   localparam int PD_LSB = 3;
   // Timer select codes
   localparam logic [1:0] TSEL_CURRENT = 2'h2;
   localparam logic [1:0] TSEL_SW12 = 2'h1;
   localparam logic [1:0] TSEL_SW3 = 2'h0;
   // Timing: counters tick every four comparison cycles
   localparam logic [1:0] TICK_DIV_LAST = 2'h3;
   localparam logic [6:0] PUMP_MAX = 7'h40;
   localparam logic [6:0] PUMP_MIN = 7'h01;
   // Reset values
   localparam logic [8:0] TOUT_RESET = 9'h000;
   localparam logic [11:0] MOD_RESET = 12'h00D;
   localparam logic [3:0] RDIV_RESET = 4'h1;
endpackage

// ==== ssrb_top.sv ====
// Serial register bank of a fractional-N synthesizer: shift port, eight
// write-only registers, double buffering and fast-lock timers.
// Assumes serial pins and the comparison reference are asynchronous to mclk.
// Summary of operation
// - Code 000 routes the latched word to the frequency word register only.
// - Code 001 writes the modulus and reference register.
// - Fraction bits 14..3 drive the modulator; host keeps below modulus.
// - First comparison cycle after a frequency write loads the divider.
// - Divider update starts fast lock at maximum pump current until timeout.
// - Divider update closes three filter switches; one and two open at a shared timeout, three at its own.
// - Modulus/reference and phase writes wait in shadow until frequency write.
// - Modulus, divider, halving, boost, doubler apply after next frequency write.
// - Boost bit raises pump current 25 percent at the update after next frequency write.
// - Halving bit inserts divide-by-two before the phase detector.
// - Doubler bit places a doubler ahead of the reference divider.
// - Modulus/reference layout: boost 23, halve 22, prescaler 20, doubler 19, modulus.
// - Code 100 holds a 9-bit timeout at 13..5 and select at 4..3.
// - Code 010 holds a 12-bit phase at 14..3.
// - Code 110 holds mux code 6..3 and settings 15..12.
// - Timeout counters tick once per four comparison cycles.
// - Select 10 current, 01 switches one/two, 00 switch three.
// - Pump outputs grounded while the grounding bit is low.
`timescale 1ns/1ps
module ssrb_top (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        ser_clk,
   input  wire logic        ser_data,
   input  wire logic        load_strobe,
   input  wire logic        pfd_ref,
   output logic [7:0]       div_integer,
   output logic [11:0]      fraction_numerator,
   output logic [11:0]      fraction_modulus,
   output logic [11:0]      phase_value,
   output logic [3:0]       ref_divider,
   output logic             ref_halve,
   output logic             ref_doubler,
   output logic             prescaler_sel,
   output logic             current_boost,
   output logic [6:0]       pump_cells,
   output logic             pump_grounding,
   output logic             pfd_polarity,
   output logic             filter_switch_one,
   output logic             filter_switch_two,
   output logic             filter_switch_three,
   output logic             fast_lock,
   output logic [4:0]       powerdown_bits,
   output logic [3:0]       test_output_pin,
   output logic [3:0]       lock_settings,
   output logic [12:0]      test_bits,
   output logic             divider_update
);
   import ssrb_pkg::*;

   // Synchronisers for the asynchronous pins
   logic [1:0] sck_sync_reg, sda_sync_reg, le_sync_reg, ref_sync_reg;
   logic       sck_d_reg, le_d_reg, ref_d_reg;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sck_sync_reg <= 2'h0;
         sda_sync_reg <= 2'h0;
         le_sync_reg  <= 2'h0;
         ref_sync_reg <= 2'h0;
         sck_d_reg    <= 1'b0;
         le_d_reg     <= 1'b0;
         ref_d_reg    <= 1'b0;
      end else begin
         sck_sync_reg <= {sck_sync_reg[0], ser_clk};
         sda_sync_reg <= {sda_sync_reg[0], ser_data};
         le_sync_reg  <= {le_sync_reg[0], load_strobe};
         ref_sync_reg <= {ref_sync_reg[0], pfd_ref};
         sck_d_reg    <= sck_sync_reg[1];
         le_d_reg     <= le_sync_reg[1];
         ref_d_reg    <= ref_sync_reg[1];
      end
   end

   // Edge detection on synchronised levels
   wire sck_rise = sck_sync_reg[1] & ~sck_d_reg;
   wire le_rise  = le_sync_reg[1] & ~le_d_reg;
   wire pfd_rise = ref_sync_reg[1] & ~ref_d_reg;

   // Input shift register, MSB first
   logic [WORD_W-1:0] shift_reg;
   always_ff @(posedge mclk) begin
      if (sys_rst)
         shift_reg <= '0;
      else if (sck_rise)
         shift_reg <= {shift_reg[WORD_W-2:0], sda_sync_reg[1]};
   end

   // Address decode of the latched word
   wire [2:0] sel     = shift_reg[2:0];
   wire wr_freq   = le_rise && (sel == SEL_FREQ);
   wire wr_modref = le_rise && (sel == SEL_MODREF);
   wire wr_phase  = le_rise && (sel == SEL_PHASE);
   wire wr_func   = le_rise && (sel == SEL_FUNC);
   wire wr_timer  = le_rise && (sel == SEL_TIMER);
   wire wr_pdown  = le_rise && (sel == SEL_PDOWN);
   wire wr_outsel = le_rise && (sel == SEL_OUTSEL);
   wire wr_test   = le_rise && (sel == SEL_TEST);
   wire [1:0] tsel = shift_reg[TSEL_LSB+1:TSEL_LSB];
   wire [8:0] tval = shift_reg[TOUT_LSB+8:TOUT_LSB];

   // Shadow stage for frequency, modulus/reference and phase
   logic [7:0]  sh_int_reg;
   logic [11:0] sh_fraction_numerator_reg, sh_mod_reg, sh_phase_reg;
   logic [3:0]  sh_rdiv_reg;
   logic        sh_boost_reg, sh_halve_reg, sh_presc_reg, sh_dbl_reg;
   logic        pend_reg;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sh_int_reg   <= 8'h00;
         sh_fraction_numerator_reg  <= 12'h000;
         sh_mod_reg   <= MOD_RESET;
         sh_phase_reg <= 12'h000;
         sh_rdiv_reg  <= RDIV_RESET;
         sh_boost_reg <= 1'b0;
         sh_halve_reg <= 1'b0;
         sh_presc_reg <= 1'b0;
         sh_dbl_reg   <= 1'b0;
         pend_reg     <= 1'b0;
      end else begin
         if (wr_freq) begin
            sh_int_reg  <= shift_reg[INT_LSB+7:INT_LSB];
            sh_fraction_numerator_reg <= shift_reg[FRACTION_NUMERATOR_LSB+11:FRACTION_NUMERATOR_LSB];
         end
         if (wr_modref) begin
            sh_boost_reg <= shift_reg[BOOST_BIT];
            sh_halve_reg <= shift_reg[HALVE_BIT];
            sh_presc_reg <= shift_reg[PRESC_BIT];
            sh_dbl_reg   <= shift_reg[DOUBLER_BIT];
            sh_rdiv_reg  <= shift_reg[RDIV_LSB+3:RDIV_LSB];
            sh_mod_reg   <= shift_reg[MOD_LSB+11:MOD_LSB];
         end
         if (wr_phase)
            sh_phase_reg <= shift_reg[PHASE_LSB+11:PHASE_LSB];
         // Set wins over the clear at the comparison edge
         if (wr_freq)
            pend_reg <= 1'b1;
         else if (pfd_rise)
            pend_reg <= 1'b0;
      end
   end

   // Second stage: settings armed by a frequency write, so later writes wait
   logic [11:0] arm_mod_reg, arm_phase_reg;
   logic [3:0]  arm_rdiv_reg;
   logic        arm_boost_reg, arm_halve_reg, arm_presc_reg, arm_dbl_reg;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         arm_mod_reg   <= MOD_RESET;
         arm_phase_reg <= 12'h000;
         arm_rdiv_reg  <= RDIV_RESET;
         arm_boost_reg <= 1'b0;
         arm_halve_reg <= 1'b0;
         arm_presc_reg <= 1'b0;
         arm_dbl_reg   <= 1'b0;
      end else if (wr_freq) begin
         arm_mod_reg   <= sh_mod_reg;
         arm_phase_reg <= sh_phase_reg;
         arm_rdiv_reg  <= sh_rdiv_reg;
         arm_boost_reg <= sh_boost_reg;
         arm_halve_reg <= sh_halve_reg;
         arm_presc_reg <= sh_presc_reg;
         arm_dbl_reg   <= sh_dbl_reg;
      end
   end

   // Divider update on the first comparison cycle after a frequency write
   wire upd = pend_reg && pfd_rise;

   // Applied settings
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         div_integer        <= 8'h00;
         fraction_numerator <= 12'h000;
         fraction_modulus   <= MOD_RESET;
         phase_value        <= 12'h000;
         ref_divider        <= RDIV_RESET;
         ref_halve          <= 1'b0;
         ref_doubler        <= 1'b0;
         prescaler_sel      <= 1'b0;
         current_boost      <= 1'b0;
         divider_update     <= 1'b0;
      end else begin
         divider_update <= upd;
         if (upd) begin
            div_integer        <= sh_int_reg;
            fraction_numerator <= sh_fraction_numerator_reg;
            fraction_modulus   <= arm_mod_reg;
            phase_value        <= arm_phase_reg;
            ref_divider        <= arm_rdiv_reg;
            ref_halve          <= arm_halve_reg;
            ref_doubler        <= arm_dbl_reg;
            prescaler_sel      <= arm_presc_reg;
            current_boost      <= arm_boost_reg;
         end
      end
   end

   // Immediate registers: function, power-down, output select, test
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pump_grounding  <= 1'b0;
         pfd_polarity    <= 1'b1;
         powerdown_bits  <= 5'h00;
         test_output_pin <= 4'h0;
         lock_settings   <= 4'h0;
         test_bits       <= 13'h0000;
      end else begin
         if (wr_func) begin
            pump_grounding <= shift_reg[GND_BIT];
            pfd_polarity   <= shift_reg[POL_BIT];
         end
         if (wr_pdown)
            powerdown_bits <= shift_reg[PD_LSB+4:PD_LSB];
         if (wr_outsel) begin
            test_output_pin <= shift_reg[MUX_LSB+3:MUX_LSB];
            lock_settings   <= shift_reg[LDSET_LSB+3:LDSET_LSB];
         end
         if (wr_test)
            test_bits <= shift_reg[15:3];
      end
   end

   // Timeout values, one for each of the three timer select codes 10, 01 and 00
   logic [8:0] tout_cur_reg, tout_sw12_reg, tout_sw3_reg;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tout_cur_reg  <= TOUT_RESET;
         tout_sw12_reg <= TOUT_RESET;
         tout_sw3_reg  <= TOUT_RESET;
      end else if (wr_timer) begin
         if (tsel == TSEL_CURRENT)
            tout_cur_reg <= tval;
         if (tsel == TSEL_SW12)
            tout_sw12_reg <= tval;
         if (tsel == TSEL_SW3)
            tout_sw3_reg <= tval;
      end
   end

   // Tick prescaler: one tick per four comparison cycles
   logic [1:0] pre_reg;
   always_ff @(posedge mclk) begin
      if (sys_rst || upd)
         pre_reg <= 2'h0;
      else if (pfd_rise)
         pre_reg <= pre_reg + 2'h1;
   end
   wire tick = pfd_rise && (pre_reg == TICK_DIV_LAST);

   // Comparison rises since the last tick, counted apart from the prescaler
   logic [2:0] rise_gap_reg;
   always_ff @(posedge mclk) begin
      if (sys_rst || upd || tick)
         rise_gap_reg <= 3'h0;
      else if (pfd_rise)
         rise_gap_reg <= rise_gap_reg + 3'h1;
   end

   // Fast-lock counters and pump ramp
   logic [8:0] cnt_cur_reg, cnt_sw12_reg, cnt_sw3_reg;
   logic       cur_run_reg, ramp_reg;
   logic [6:0] cells_reg;
   wire cur_done = cur_run_reg && ((cnt_cur_reg == 9'h000) ||
                   (tick && cnt_cur_reg == 9'h001));
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cnt_cur_reg         <= 9'h000;
         cnt_sw12_reg        <= 9'h000;
         cnt_sw3_reg         <= 9'h000;
         cur_run_reg         <= 1'b0;
         ramp_reg            <= 1'b0;
         cells_reg           <= PUMP_MIN;
         filter_switch_one   <= 1'b0;
         filter_switch_two   <= 1'b0;
         filter_switch_three <= 1'b0;
      end else if (upd) begin
         cnt_cur_reg         <= tout_cur_reg;
         cnt_sw12_reg        <= tout_sw12_reg;
         cnt_sw3_reg         <= tout_sw3_reg;
         cur_run_reg         <= 1'b1;
         ramp_reg            <= 1'b0;
         cells_reg           <= PUMP_MAX;
         filter_switch_one   <= 1'b1;
         filter_switch_two   <= 1'b1;
         filter_switch_three <= 1'b1;
      end else begin
         if (tick && cnt_cur_reg != 9'h000)
            cnt_cur_reg <= cnt_cur_reg - 9'h001;
         if (tick && cnt_sw12_reg != 9'h000)
            cnt_sw12_reg <= cnt_sw12_reg - 9'h001;
         if (tick && cnt_sw3_reg != 9'h000)
            cnt_sw3_reg <= cnt_sw3_reg - 9'h001;
         if (cnt_sw12_reg == 9'h000 || (tick && cnt_sw12_reg == 9'h001)) begin
            filter_switch_one <= 1'b0;
            filter_switch_two <= 1'b0;
         end
         if (cnt_sw3_reg == 9'h000 || (tick && cnt_sw3_reg == 9'h001))
            filter_switch_three <= 1'b0;
         if (cur_done) begin
            cur_run_reg <= 1'b0;
            ramp_reg    <= 1'b1;
         end
         if (ramp_reg && tick) begin
            cells_reg <= {1'b0, cells_reg[6:1]};
            if (cells_reg[6:1] == PUMP_MIN)
               ramp_reg <= 1'b0;
         end
      end
   end

   // Pump cell output, forced off while grounded
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pump_cells <= 7'h00;
         fast_lock  <= 1'b0;
      end else begin
         pump_cells <= pump_grounding ? cells_reg : 7'h00;
         fast_lock  <= cur_run_reg || ramp_reg;
      end
   end

   a_pump_max_update: assert property (@(posedge mclk) disable iff (sys_rst)
      upd |=> cells_reg == PUMP_MAX && cur_run_reg)
      else $error("pump not at maximum after update");
   a_switches_close: assert property (@(posedge mclk) disable iff (sys_rst)
      upd |=> filter_switch_one && filter_switch_two && filter_switch_three)
      else $error("filter switches not closed on update");
   a_divider_load: assert property (@(posedge mclk) disable iff (sys_rst)
      upd |=> div_integer == $past(sh_int_reg) &&
              fraction_modulus == $past(arm_mod_reg))
      else $error("divider not loaded from shadow");
   a_shadow_hold: assert property (@(posedge mclk) disable iff (sys_rst)
      !upd |=> $stable(fraction_modulus) && $stable(phase_value))
      else $error("buffered setting changed without update");
   a_ground_pump: assert property (@(posedge mclk) disable iff (sys_rst)
      !pump_grounding |=> pump_cells == 7'h00)
      else $error("pump active while grounded");
   a_func_immediate: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_func |=> pump_grounding == $past(shift_reg[GND_BIT]))
      else $error("function write not immediate");
   a_freq_decode: assert property (@(posedge mclk) disable iff (sys_rst)
      (le_rise && sel != SEL_FREQ && !pend_reg) |=> !pend_reg)
      else $error("non-frequency code started update");
   a_ramp_halves: assert property (@(posedge mclk) disable iff (sys_rst)
      (ramp_reg && tick && !upd) |=> cells_reg == {1'b0, $past(cells_reg[6:1])})
      else $error("pump ramp step wrong");
   a_tick_period: assert property (@(posedge mclk) disable iff (sys_rst)
      tick |-> rise_gap_reg == {1'b0, TICK_DIV_LAST})
      else $error("tick not on fourth cycle");
   a_test_write: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_test |=> test_bits == $past(shift_reg[15:3]))
      else $error("test register not written");
endmodule

// ==== ssrb_host.sv ====
// Host model that drives the three-wire serial port of the register bank.
// Assumes mclk comes from the bench; one serial bit lasts 8 mclk (320 ns).
`timescale 1ns/1ps
module ssrb_host (
   input  wire logic mclk,
   output logic      ser_clk,
   output logic      ser_data,
   output logic      load_strobe
);
   // Idle levels: the serial clock stands low between frames
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      load_strobe = 1'b0;
   end
   // Half a serial bit
   task automatic half_bit();
      repeat (4) @(posedge mclk);
   endtask
   // Shift a whole word MSB first, then pulse the load strobe
   task automatic send_word(input logic [23:0] w);
      for (int i = 23; i >= 0; i--) begin
         ser_data <= w[i];
         half_bit();
         ser_clk <= 1'b1;
         half_bit();
         ser_clk <= 1'b0;
      end
      half_bit();
      load_strobe <= 1'b1;
      ser_data <= ~w[0]; // Released line shows the inverse
      half_bit();
      load_strobe <= 1'b0;
   endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the serial register bank.
// Assumes the host model in ssrb_host and a 25 MHz mclk.
`timescale 1ns/1ps
module tb;
   import ssrb_pkg::*;
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        pfd_ref = 1'b0;
   logic        ser_clk, ser_data, load_strobe;
   logic [7:0]  div_integer;
   logic [11:0] fraction_numerator, fraction_modulus, phase_value;
   logic [3:0]  ref_divider, test_output_pin, lock_settings;
   logic        ref_halve, ref_doubler, prescaler_sel, current_boost;
   logic [6:0]  pump_cells;
   logic        pump_grounding, pfd_polarity, fast_lock, divider_update;
   logic        filter_switch_one, filter_switch_two, filter_switch_three;
   logic [4:0]  powerdown_bits;
   logic [12:0] test_bits;
   int          n_fail = 0;
   int          n_tests = 0;
   // Clock at 40 ns period
   always #20 mclk = ~mclk;
   ssrb_host host (.mclk, .ser_clk, .ser_data, .load_strobe);
   ssrb_top dut (.mclk, .sys_rst, .ser_clk, .ser_data, .load_strobe, .pfd_ref,
      .div_integer, .fraction_numerator, .fraction_modulus, .phase_value, .ref_divider,
      .ref_halve, .ref_doubler, .prescaler_sel, .current_boost, .pump_cells,
      .pump_grounding, .pfd_polarity, .filter_switch_one, .filter_switch_two,
      .filter_switch_three, .fast_lock, .powerdown_bits, .test_output_pin,
      .lock_settings, .test_bits, .divider_update);
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Verdict and end of run
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // One register write, then let the synchronizers settle
   task automatic write(input logic [23:0] w);
      @(posedge mclk);
      host.send_word(w);
      repeat (8) @(posedge mclk);
      #1;
   endtask
   // Comparison reference pulses
   task automatic pfd(input int n);
      repeat (n) begin
         @(posedge mclk);
         pfd_ref <= 1'b1;
         repeat (4) @(posedge mclk);
         pfd_ref <= 1'b0;
         repeat (3) @(posedge mclk);
      end
      #1;
   endtask
   // One reference rise that must apply a pending frequency word
   task automatic update();
      @(posedge mclk);
      pfd_ref <= 1'b1;
      for (int i = 0; i < 12 && divider_update !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      chk(divider_update, 1, "update pulse");
      @(posedge mclk);
      pfd_ref <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   // Word builders
   function automatic logic [23:0] tmr(input logic [8:0] v, input logic [1:0] s);
      return 24'h004000 | (24'(v) << TOUT_LSB) | (24'(s) << TSEL_LSB) | 24'(SEL_TIMER);
   endfunction
   function automatic logic [23:0] frq(input logic [7:0] n, input logic [11:0] f);
      return (24'(n) << INT_LSB) | (24'(f) << FRACTION_NUMERATOR_LSB) | 24'(SEL_FREQ);
   endfunction
   // Watchdog
   initial begin
      repeat (30000) @(posedge mclk);
      n_fail++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      complete_run();
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      #1;
      chk(fraction_modulus, 24'h00000D, "reset modulus");
      chk(ref_divider, 24'h1, "reset divider");
      chk({pfd_polarity, pump_cells, filter_switch_one}, 24'h100, "reset pump");
      $display("test reset done");
      // Immediate registers
      write(24'h000073);
      chk({pump_grounding, pfd_polarity}, 24'h2, "function setup");
      write(24'h0000B5);
      chk(powerdown_bits, 24'h16, "power-down bits");
      write(24'h00A04E);
      chk({lock_settings, test_output_pin}, 24'hA9, "output select");
      write(24'h000007);
      chk(test_bits, 24'h0, "test register");
      $display("test immediate done");
      // Timers, shadowed settings, first channel
      write(tmr(9'h002, TSEL_CURRENT));
      write(tmr(9'h002, TSEL_SW12));
      write(tmr(9'h006, TSEL_SW3));
      write(24'hDA8321);
      write(24'h00091A);
      chk({current_boost, ref_halve, ref_doubler}, 24'h0, "shadow flags");
      chk({ref_divider, fraction_modulus, phase_value}, 32'h0100D000, "shadow values");
      write(frq(8'd30, 12'd50));
      chk(div_integer, 24'h0, "before comparison");
      update();
      chk({div_integer, fraction_numerator}, {8'd30, 12'd50}, "divider");
      chk(fraction_modulus, 24'd100, "modulus applied");
      chk({ref_divider, phase_value}, 24'h5123, "divider and phase");
      chk({current_boost, ref_halve}, 24'h3, "boost halve");
      chk({prescaler_sel, ref_doubler}, 24'h3, "presc doubler");
      chk({pump_cells, fast_lock}, {7'h40, 1'b1}, "fast lock");
      chk({filter_switch_one, filter_switch_two, filter_switch_three}, 24'h7, "closed");
      $display("test channel done");
      // Timeout expiry
      pfd(16);
      chk({filter_switch_one, filter_switch_two}, 24'h0, "sw12 open");
      chk(filter_switch_three, 24'h1, "sw3 closed");
      pfd(24);
      chk(filter_switch_three, 24'h0, "sw3 open");
      chk({pump_cells, fast_lock}, {7'h01, 1'b0}, "ramp done");
      $display("test timeout done");
      // Channel change by frequency word; a later modulus/reference write stays in shadow
      write(frq(8'd200, 12'd7));
      write(24'h028641);
      update();
      chk({div_integer, fraction_numerator}, {8'd200, 12'd7}, "new channel");
      chk({fraction_modulus, ref_divider}, {12'd100, 4'h5}, "kept settings");
      chk(pump_cells, 24'h40, "fast lock again");
      $display("test rechannel done");
      // Grounding the pump outputs
      write(24'h000053);
      chk({pump_grounding, pump_cells}, 24'h0, "grounded");
      $display("test grounding done");
      complete_run();
   end
endmodule
